// file: verilog/serial_port_status.sv
// serial port status flags with a small serial engine and wishbone slave
//
// The implementer's own choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps

module serial_port_status
  import serial_port_pkg::*;
#(
  parameter int TICK_DIV = 8 // clk_i cycles per internal serial tick
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // classic wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // serial link
  input wire logic rx_i,
  input wire logic sclk_i,
  output logic tx_o,
  // power control and requests
  input wire logic stop_i,
  output logic idle_irq_o
);

  // ==========================================================================
  // synchronisers for pins outside the clock domain
  logic rx_m_r, rx_s_r, sclk_m_r, sclk_s_r, sclk_d_r, stop_m_r, stop_s_r;

  // two flops on each pin, plus the previous serial clock level
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_m_r <= 1'b1;
      rx_s_r <= 1'b1;
      sclk_m_r <= 1'b0;
      sclk_s_r <= 1'b0;
      sclk_d_r <= 1'b0;
      stop_m_r <= 1'b0;
      stop_s_r <= 1'b0;
    end else begin
      rx_m_r <= rx_i;
      rx_s_r <= rx_m_r;
      sclk_m_r <= sclk_i;
      sclk_s_r <= sclk_m_r;
      sclk_d_r <= sclk_s_r;
      stop_m_r <= stop_i;
      stop_s_r <= stop_m_r;
    end
  end

  // ==========================================================================
  // control register and bus slave
  ctrl_t ctrl_r, ctrl_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] dat_r, dat_nxt;
  logic status_armed_r, status_armed_nxt; // status read seen
  status_t flags;                         // current flag view
  logic [7:0] rx_data_r;
  logic req, rd_status, rd_rx, wr_tx, wr_txa;
  logic flag_clr;                         // one-shot soft reset or stop

  assign req = wb_cyc_i & wb_stb_i & ~ack_r;
  assign rd_status = req & ~wb_we_i & (wb_adr_i == ADDR_STATUS);
  assign rd_rx = req & ~wb_we_i & (wb_adr_i == ADDR_RX_DATA);
  assign wr_txa = req & wb_we_i & wb_sel_i[0] & (wb_adr_i == ADDR_TX_ADDR);
  assign wr_tx = req & wb_we_i & wb_sel_i[0] &
                 ((wb_adr_i == ADDR_TX_DATA0) | (wb_adr_i == ADDR_TX_DATA1) |
                  (wb_adr_i == ADDR_TX_DATA2) | wr_txa);
  // software reset comes through the one-shot bit, stop through the synchronised stop pin
  assign flag_clr = ctrl_r.soft_reset | stop_s_r;

  // bus decode, read mux and control writes
  always_comb begin
    ctrl_nxt = ctrl_r;
    ctrl_nxt.soft_reset = 1'b0; // one-shot bits fall back
    ctrl_nxt.send_break = 1'b0;
    ack_nxt = req;
    dat_nxt = dat_r;
    status_armed_nxt = status_armed_r;
    if (req && !wb_we_i) begin
      unique case (wb_adr_i)
        ADDR_STATUS: dat_nxt = {24'h000000, flags};
        ADDR_CTRL: dat_nxt = {{(32 - CTRL_W){1'b0}}, ctrl_r};
        ADDR_RX_DATA: dat_nxt = {24'h000000, rx_data_r};
        default: dat_nxt = 32'h00000000; // unmapped reads zero
      endcase
    end
    if (req && wb_we_i && wb_sel_i[0] && wb_adr_i == ADDR_CTRL) begin
      ctrl_nxt = ctrl_t'(wb_dat_i[CTRL_W-1:0]);
    end
    // a status write lands nowhere
    if (rd_status) begin
      status_armed_nxt = 1'b1;
    end else if (rd_rx || flag_clr) begin
      status_armed_nxt = 1'b0;
    end
  end

  // bus registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= '0;
      ack_r <= 1'b0;
      dat_r <= 32'h00000000;
      status_armed_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
      status_armed_r <= status_armed_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  // ==========================================================================
  // serial tick: internal divider or edge of the link clock
  logic [15:0] div_r, div_nxt;
  logic int_tick, tick;
  logic sync_mode, long_fmt;
  logic [4:0] tpb; // ticks per bit

  assign sync_mode = (ctrl_r.fmt == FMT_8_SYNC);
  assign long_fmt = (ctrl_r.fmt == FMT_11_PARITY) |
                    (ctrl_r.fmt == FMT_11_MULTIDROP);
  assign tpb = sync_mode ? SYNC_TICKS_PER_BIT : ASYNC_TICKS_PER_BIT;
  assign int_tick = (div_r == 16'(TICK_DIV - 1));
  // a stopped external clock gives no ticks, so all serial logic halts
  assign tick = ctrl_r.ext_clk ? (sclk_s_r & ~sclk_d_r) : int_tick;

  // divider next value
  always_comb begin
    div_nxt = int_tick ? 16'h0000 : div_r + 16'h0001;
  end

  // divider register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_r <= 16'h0000;
    end else begin
      div_r <= div_nxt;
    end
  end

  // ==========================================================================
  // receiver: framing, idle detection and receive flags
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_st_t;
  rx_st_t rx_st_r, rx_st_nxt;
  logic [4:0] rx_tick_r, rx_tick_nxt;
  logic [3:0] rx_bit_r, rx_bit_nxt;
  logic [8:0] rx_sh_r, rx_sh_nxt;
  logic [8:0] ones_r, ones_nxt;    // ticks of ones in current bit count
  logic [3:0] ones_bits_r, ones_bits_nxt;
  status_t rxf_r, rxf_nxt;         // receive side flags live here
  logic [7:0] rx_data_nxt;
  logic idle_irq_r, idle_irq_nxt;
  logic mid_bit, bit_end, stop_ok, par_bad;

  assign mid_bit = (rx_tick_r == (tpb >> 1));
  assign bit_end = (rx_tick_r == tpb - 5'h01);
  assign stop_ok = rx_s_r;
  assign par_bad = (ctrl_r.fmt == FMT_11_PARITY) & (^rx_sh_r);

  // receiver next state
  always_comb begin
    rx_st_nxt = rx_st_r;
    rx_tick_nxt = rx_tick_r;
    rx_bit_nxt = rx_bit_r;
    rx_sh_nxt = rx_sh_r;
    ones_nxt = ones_r;
    ones_bits_nxt = ones_bits_r;
    rxf_nxt = rxf_r;
    rx_data_nxt = rx_data_r;
    // reads clear first so that a flag set by a landing byte wins
    // status read then data read clears the error flags
    if (rd_rx && status_armed_r) begin
      rxf_nxt.overrun_flag = 1'b0;
      rxf_nxt.framing_error_flag = 1'b0;
      rxf_nxt.parity_error_flag = 1'b0;
    end
    if (rd_rx) begin
      rxf_nxt.rx_full_flag = 1'b0;
    end
    if (tick) begin
      // count whole bit times of ones on the line
      if (!rx_s_r) begin
        ones_nxt = 9'h000;
        ones_bits_nxt = 4'h0;
      end else if (ones_r[4:0] == tpb - 5'h01) begin
        ones_nxt = 9'h000;
        if (ones_bits_r != 4'hF) begin
          ones_bits_nxt = ones_bits_r + 4'h1;
        end
      end else begin
        ones_nxt = ones_r + 9'h001;
      end
      if (ones_bits_nxt == (long_fmt ? IDLE_BITS_LONG : IDLE_BITS_SHORT)) begin
        rxf_nxt.idle_flag = 1'b1;
      end
      rx_tick_nxt = rx_tick_r + 5'h01;
      unique case (rx_st_r)
        RX_IDLE: begin
          rx_tick_nxt = 5'h00;
          if (!rx_s_r) begin
            rx_st_nxt = RX_START;
            rxf_nxt.idle_flag = 1'b0;
          end
        end
        RX_START: begin
          if (mid_bit) begin
            // a glitch shorter than half a bit is not a start
            rx_st_nxt = rx_s_r ? RX_IDLE : RX_DATA;
            rx_tick_nxt = 5'h00;
            rx_bit_nxt = 4'h0;
          end
        end
        RX_DATA: begin
          // count restarted mid start bit, so bit_end is mid data bit
          if (bit_end) begin
            rx_tick_nxt = 5'h00;
            rx_sh_nxt = long_fmt ? {rx_s_r, rx_sh_r[8:1]}
                                 : {1'b0, rx_s_r, rx_sh_r[7:1]};
            rx_bit_nxt = rx_bit_r + 4'h1;
            if (rx_bit_nxt ==
                (long_fmt ? DATA_BITS_LONG : DATA_BITS_SHORT)) begin
              rx_st_nxt = RX_STOP;
            end
          end
        end
        RX_STOP: begin
          // stop bit sampled in its middle
          if (bit_end) begin
            rx_st_nxt = RX_IDLE;
            if (rxf_r.rx_full_flag) begin
              // old byte kept, new one dropped
              rxf_nxt.overrun_flag = 1'b1;
              rxf_nxt.framing_error_flag = 1'b0;
              rxf_nxt.parity_error_flag = 1'b0;
            end else if (!rxf_r.framing_error_flag) begin
              // framing error blocks transfers until cleared
              rx_data_nxt = rx_sh_r[7:0];
              rxf_nxt.rx_bit8 = long_fmt & rx_sh_r[8];
              rxf_nxt.rx_full_flag = 1'b1;
              rxf_nxt.framing_error_flag = ~stop_ok;
              rxf_nxt.parity_error_flag = par_bad;
            end
          end
        end
      endcase
    end
    if (flag_clr) begin
      rxf_nxt.overrun_flag = 1'b0;
      rxf_nxt.framing_error_flag = 1'b0;
      rxf_nxt.parity_error_flag = 1'b0;
      rxf_nxt.rx_bit8 = 1'b0;
    end
    // interrupt request on the rising edge of idle
    idle_irq_nxt = ctrl_r.idle_irq_enable & rxf_nxt.idle_flag &
                   ~rxf_r.idle_flag;
  end

  // receiver registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_st_r <= RX_IDLE;
      rx_tick_r <= 5'h00;
      rx_bit_r <= 4'h0;
      rx_sh_r <= 9'h000;
      ones_r <= 9'h000;
      ones_bits_r <= 4'h0;
      rxf_r <= '0;
      rx_data_r <= 8'h00;
      idle_irq_r <= 1'b0;
    end else begin
      rx_st_r <= rx_st_nxt;
      rx_tick_r <= rx_tick_nxt;
      rx_bit_r <= rx_bit_nxt;
      rx_sh_r <= rx_sh_nxt;
      ones_r <= ones_nxt;
      ones_bits_r <= ones_bits_nxt;
      rxf_r <= rxf_nxt;
      rx_data_r <= rx_data_nxt;
      idle_irq_r <= idle_irq_nxt;
    end
  end

  assign idle_irq_o = idle_irq_r;

  // ==========================================================================
  // transmitter: holding register, shifter and empty flags
  typedef enum logic [1:0] {TX_IDLE, TX_LOAD, TX_SEND} tx_st_t;
  tx_st_t tx_st_r, tx_st_nxt;
  logic [8:0] tx_hold_r, tx_hold_nxt; // bit 8 marks an address word
  logic [10:0] tx_sh_r, tx_sh_nxt;
  logic [4:0] tx_tick_r, tx_tick_nxt;
  logic [3:0] tx_bit_r, tx_bit_nxt;
  logic [3:0] tx_wait_r, tx_wait_nxt;
  logic tx_reg_empty_flag_r, tx_reg_empty_flag_nxt, transmitter_empty_flag_r, transmitter_empty_flag_nxt, brk_r, brk_nxt, tx_r, tx_nxt;
  logic [3:0] frame_bits;
  logic flag_point;

  assign frame_bits = sync_mode ? FRAME_BITS_SYNC :
                      long_fmt ? FRAME_BITS_LONG : FRAME_BITS_SHORT;
  // async: two oversample ticks into the first data bit
  // sync: middle of the second bit
  assign flag_point = (tx_bit_r == 4'h1) &&
                      (tx_tick_r == (sync_mode ? (tpb >> 1)
                                               : ASYNC_FLAG_TICK));

  // transmitter next state
  always_comb begin
    tx_st_nxt = tx_st_r;
    tx_hold_nxt = tx_hold_r;
    tx_sh_nxt = tx_sh_r;
    tx_tick_nxt = tx_tick_r;
    tx_bit_nxt = tx_bit_r;
    tx_wait_nxt = tx_wait_r;
    tx_reg_empty_flag_nxt = tx_reg_empty_flag_r;
    brk_nxt = brk_r | ctrl_r.send_break;
    tx_nxt = tx_r;
    if (tick) begin
      unique case (tx_st_r)
        TX_IDLE: begin
          tx_nxt = 1'b1; // line idles high
          if (!tx_reg_empty_flag_r || brk_r) begin
            tx_st_nxt = sync_mode ? TX_LOAD : TX_SEND;
            tx_wait_nxt = 4'h0;
            tx_tick_nxt = 5'h00;
            tx_bit_nxt = 4'h0;
            if (brk_r) begin
              tx_sh_nxt = 11'h000; // a break frame is all zeros
              brk_nxt = 1'b0;
            end else if (sync_mode) begin
              tx_sh_nxt = {3'h0, tx_hold_r[7:0]};
            end else if (ctrl_r.fmt == FMT_11_PARITY) begin
              tx_sh_nxt = {1'b1, ^tx_hold_r[7:0], tx_hold_r[7:0], 1'b0};
            end else if (long_fmt) begin
              tx_sh_nxt = {1'b1, tx_hold_r[8], tx_hold_r[7:0], 1'b0};
            end else begin
              tx_sh_nxt = {2'h3, tx_hold_r[7:0], 1'b0};
            end
          end
        end
        TX_LOAD: begin
          // synchronous mode waits two bit times before shifting out the loaded word
          tx_tick_nxt = tx_tick_r + 5'h01;
          if (tx_tick_r == tpb - 5'h01) begin
            tx_tick_nxt = 5'h00;
            tx_wait_nxt = tx_wait_r + 4'h1;
            if (tx_wait_r == SYNC_LOAD_BITS - 4'h1) begin
              tx_st_nxt = TX_SEND;
            end
          end
        end
        TX_SEND: begin
          tx_nxt = tx_sh_r[0];
          tx_tick_nxt = tx_tick_r + 5'h01;
          if (flag_point && !brk_r) begin
            tx_reg_empty_flag_nxt = 1'b1;
          end
          if (tx_tick_r == tpb - 5'h01) begin
            tx_tick_nxt = 5'h00;
            tx_sh_nxt = {1'b1, tx_sh_r[10:1]};
            tx_bit_nxt = tx_bit_r + 4'h1;
            if (tx_bit_r == frame_bits - 4'h1) begin
              tx_st_nxt = TX_IDLE;
            end
          end
        end
        // the unused state code falls back to idle
        default: tx_st_nxt = TX_IDLE;
      endcase
    end
    // a write fills the holding register and clears the flag
    if (wr_tx) begin
      tx_hold_nxt = {wr_txa, wb_dat_i[7:0]};
      tx_reg_empty_flag_nxt = 1'b0;
    end
    if (flag_clr) begin
      tx_reg_empty_flag_nxt = 1'b1;
    end
    // empty only with no frame in flight and nothing held
    // so a write while empty is the very next frame sent
    transmitter_empty_flag_nxt = (tx_st_nxt == TX_IDLE) & tx_reg_empty_flag_nxt & ~brk_nxt;
  end

  // transmitter registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_st_r <= TX_IDLE;
      tx_hold_r <= 9'h000;
      tx_sh_r <= 11'h7FF;
      tx_tick_r <= 5'h00;
      tx_bit_r <= 4'h0;
      tx_wait_r <= 4'h0;
      tx_reg_empty_flag_r <= STATUS_RESET.tx_reg_empty_flag;
      transmitter_empty_flag_r <= STATUS_RESET.transmitter_empty_flag;
      brk_r <= 1'b0;
      tx_r <= 1'b1;
    end else begin
      tx_st_r <= tx_st_nxt;
      tx_hold_r <= tx_hold_nxt;
      tx_sh_r <= tx_sh_nxt;
      tx_tick_r <= tx_tick_nxt;
      tx_bit_r <= tx_bit_nxt;
      tx_wait_r <= tx_wait_nxt;
      tx_reg_empty_flag_r <= tx_reg_empty_flag_nxt;
      transmitter_empty_flag_r <= transmitter_empty_flag_nxt;
      brk_r <= brk_nxt;
      tx_r <= tx_nxt;
    end
  end

  assign tx_o = tx_r;

  // ==========================================================================
  // status view gathered from both halves
  always_comb begin
    flags = rxf_r;
    flags.tx_reg_empty_flag = tx_reg_empty_flag_r;
    flags.transmitter_empty_flag = transmitter_empty_flag_r;
  end

endmodule

// file: verilog/serial_port_pkg.sv
// constants, field layouts and carrier types of the serial port status block
// ============================================================================
package serial_port_pkg;

  // ==========================================================================
  // register byte addresses on the bus
  localparam logic [4:0] ADDR_STATUS = 5'h00;
  localparam logic [4:0] ADDR_CTRL = 5'h04;
  localparam logic [4:0] ADDR_RX_DATA = 5'h08;
  localparam logic [4:0] ADDR_TX_DATA0 = 5'h0C;
  localparam logic [4:0] ADDR_TX_DATA1 = 5'h10;
  localparam logic [4:0] ADDR_TX_DATA2 = 5'h14;
  localparam logic [4:0] ADDR_TX_ADDR = 5'h18;

  // ==========================================================================
  // word formats held in the control register
  localparam logic [1:0] FMT_10_ASYNC = 2'h0;
  localparam logic [1:0] FMT_11_PARITY = 2'h1;
  localparam logic [1:0] FMT_11_MULTIDROP = 2'h2;
  localparam logic [1:0] FMT_8_SYNC = 2'h3;

  // ==========================================================================
  // timing in serial clock ticks and in bit counts
  localparam logic [4:0] ASYNC_TICKS_PER_BIT = 5'h10; // 16x oversampling
  localparam logic [4:0] SYNC_TICKS_PER_BIT = 5'h02;  // two ticks per bit
  localparam logic [4:0] ASYNC_FLAG_TICK = 5'h01;     // 2nd tick of bit 1
  localparam logic [3:0] SYNC_LOAD_BITS = 4'h2;       // load delay in bits
  localparam logic [3:0] IDLE_BITS_SHORT = 4'hA;      // ten ones
  localparam logic [3:0] IDLE_BITS_LONG = 4'hB;       // eleven ones
  localparam logic [3:0] DATA_BITS_SHORT = 4'h8;
  localparam logic [3:0] DATA_BITS_LONG = 4'h9;
  localparam logic [3:0] FRAME_BITS_SHORT = 4'hA;
  localparam logic [3:0] FRAME_BITS_LONG = 4'hB;
  localparam logic [3:0] FRAME_BITS_SYNC = 4'h8;

  // ==========================================================================
  // control register layout, high bits first
  typedef struct packed {
    logic send_break;      // [5] one-shot: send a break frame
    logic soft_reset;      // [4] one-shot: individual port reset
    logic ext_clk;         // [3] serial clock from the link pin
    logic idle_irq_enable; // [2] idle interrupt enable
    logic [1:0] fmt;       // [1:0] word format
  } ctrl_t;
  localparam int CTRL_W = 6;

  // status register layout, bit 7 first
  typedef struct packed {
    logic rx_bit8;                 // [7] received ninth bit
    logic framing_error_flag;      // [6]
    logic parity_error_flag;       // [5]
    logic overrun_flag;            // [4]
    logic idle_flag;               // [3]
    logic rx_full_flag;            // [2]
    logic tx_reg_empty_flag;       // [1]
    logic transmitter_empty_flag;  // [0]
  } status_t;

  // status reset value: both transmit flags set
  localparam status_t STATUS_RESET = 8'h03;

endpackage

// file: tb/serial_partner.sv
// remote serial device model driving the receive line and link clock
`timescale 1ns/1ps

module serial_partner #(
  parameter int BIT_NS = 3200 // one async bit time in ns
) (
  // line from the block under test
  input wire logic tx_i,
  // lines toward the block under test
  output logic rx_o,
  output logic sclk_o
);
  logic [7:0] got; // last byte seen on the transmit line

  // ==========================================================================
  // idle line high, link clock still outside frames
  initial begin
    rx_o = 1'b1;
    sclk_o = 1'b0;
    got = 8'h00;
  end

  // send start, n bits lsb first, then a stop bit (low when broken)
  task automatic send(input logic [8:0] d, input int n, input logic ok);
    rx_o = 1'b0;
    #(BIT_NS);
    for (int i = 0; i < n; i++) begin
      rx_o = d[i];
      #(BIT_NS);
    end
    rx_o = ok;
    #(BIT_NS);
    rx_o = 1'b1;
  endtask

  // run the link clock for n periods of 800 ns, then hold it low
  task automatic clock(input int n);
    repeat (n) begin
      sclk_o = 1'b1;
      #400;
      sclk_o = 1'b0;
      #400;
    end
  endtask

  // sample each transmitted byte in mid bit after its start bit
  always @(negedge tx_i) begin
    #(BIT_NS * 3 / 2);
    for (int i = 0; i < 8; i++) begin
      got[i] = tx_i;
      #(BIT_NS);
    end
  end
endmodule

// file: tb/serial_port_status_chk.sv
// port-level assertions for the serial port status block
`timescale 1ns/1ps

module serial_port_status_chk
  import serial_port_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bus signals
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // power control and requests
  input wire logic stop_i,
  input wire logic idle_irq_o
);
  logic req, rd_st, tx_wr, rx_rd; // decoded bus events
  logic [4:0] since_tx, since_rx, stop_cnt; // cycle counters
  logic [4:0] tx_nxt, rx_nxt, stop_nxt;

  // ==========================================================================
  // bus decode and saturating counters
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign rd_st = wb_ack_o && !wb_we_i && wb_adr_i == ADDR_STATUS;
  assign tx_wr = req && wb_we_i && wb_adr_i inside {ADDR_TX_DATA0,
    ADDR_TX_DATA1, ADDR_TX_DATA2, ADDR_TX_ADDR};
  assign rx_rd = req && !wb_we_i && wb_adr_i == ADDR_RX_DATA;
  assign tx_nxt = tx_wr ? 5'h00 : since_tx + {4'h0, since_tx != 5'h1F};
  assign rx_nxt = rx_rd ? 5'h00 : since_rx + {4'h0, since_rx != 5'h1F};
  assign stop_nxt = !stop_i ? 5'h00 : stop_cnt + {4'h0, stop_cnt != 5'h1F};

  // registers of the counters
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      since_tx <= 5'h1F;
      since_rx <= 5'h1F;
      stop_cnt <= 5'h00;
    end else begin
      since_tx <= tx_nxt;
      since_rx <= rx_nxt;
      stop_cnt <= stop_nxt;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ==========================================================================
  // assertions
  AST_ACK_NEXT: assert property (req |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(req) ##1 !wb_ack_o)
    else $error("ack without request or longer than one cycle");
  AST_STATUS_HIGH: assert property (rd_st |-> wb_dat_o[31:8] == 24'h000000)
    else $error("status upper bits not zero");
  AST_TRANSMITTER_EMPTY_FLAG_TX_REG_EMPTY_FLAG: assert property (rd_st |-> !wb_dat_o[0] || wb_dat_o[1])
    else $error("transmitter empty while data register full");
  AST_OR_PRIO: assert property (
    rd_st && wb_dat_o[4] |-> !wb_dat_o[6] && !wb_dat_o[5])
    else $error("error flags beside overrun");
  AST_TX_WRITE: assert property (
    rd_st && since_tx < 5'h0A |-> wb_dat_o[1:0] == 2'h0)
    else $error("transmit flags set right after write");
  AST_RX_READ: assert property (
    rd_st && since_rx < 5'h0A |-> !wb_dat_o[2])
    else $error("receive full stays after data read");
  AST_STOP: assert property (
    rd_st && stop_cnt > 5'h07 |-> wb_dat_o[1] && wb_dat_o[6:4] == 3'h0)
    else $error("stop did not clear or set flags");
  AST_IRQ_PULSE: assert property ($rose(idle_irq_o) |=> !idle_irq_o)
    else $error("idle request longer than one cycle");

  // main scenarios reached
  COV_OVERRUN: cover property (rd_st && wb_dat_o[4]);
  COV_IDLE_IRQ: cover property (idle_irq_o);
  COV_STOP: cover property (rd_st && stop_cnt > 5'h07);
endmodule

bind serial_port_status serial_port_status_chk u_chk (.clk_i(clk_i),
  .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .stop_i(stop_i), .idle_irq_o(idle_irq_o));

// file: tb/tb_top.sv
// self-checking bench for the serial port status block
`timescale 1ns/1ps

module tb_top;
  import serial_port_pkg::*;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic rx_i, sclk_i, tx_o, stop_i, idle_irq_o;
  logic [4:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  int bad_count = 0;
  int checked = 0;
  int irqs = 0;
  int n0;

  // design with a short tick so frames stay brief
  serial_port_status #(.TICK_DIV(2)) dut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_i(rx_i), .sclk_i(sclk_i),
    .tx_o(tx_o), .stop_i(stop_i), .idle_irq_o(idle_irq_o));
  // remote device: one bit is 16 ticks of 2 clocks
  serial_partner #(.BIT_NS(3200)) rem (.tx_i(tx_o), .rx_o(rx_i),
    .sclk_o(sclk_i));

  // ==========================================================================
  // clock, request counter and watchdog
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  always @(posedge clk_i) if (idle_irq_o === 1'b1) irqs <= irqs + 1;
  initial begin
    #3000000;
    bad_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    final_report();
  end

  // ==========================================================================
  // shared tasks
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic chk(input logic [31:0] got, exp, input string m);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s got %h want %h", $time, m, got, exp);
    end
  endtask
  // one classic cycle, held until ack is seen at a rising edge
  task automatic wb(input logic we, input logic [4:0] a, input logic [7:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= {24'h000000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    chk(32'(n), 32'h00000002, "ack one cycle after the request");
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // status read compared under a mask
  task automatic st(input logic [7:0] m, e, input string s);
    wb(1'b0, ADDR_STATUS, 8'h00);
    chk(rd & {24'hFFFFFF, m}, {24'h000000, e}, s);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_reset;
    st(8'hF7, 8'h03, "reset status");
    wb(1'b1, ADDR_STATUS, 8'hFC);
    st(8'hF7, 8'h03, "status write");
    wb(1'b0, 5'h1C, 8'h00);
    chk(rd, 32'h00000000, "unmapped read");
    $display("test reset done");
  endtask
  task automatic t_rx;
    wb(1'b1, ADDR_CTRL, 8'h04);
    rem.send(9'h0A5, 8, 1'b1);
    cyc(4);
    n0 = irqs;
    st(8'hFF, 8'h07, "full, idle cleared");
    wb(1'b0, ADDR_RX_DATA, 8'h00);
    chk(rd, 32'h000000A5, "received byte");
    st(8'hFF, 8'h03, "read clears full");
    cyc(7 * 32);
    st(8'h08, 8'h00, "idle too early");
    cyc(4 * 32);
    st(8'h08, 8'h08, "idle after ten ones");
    chk(32'(irqs - n0), 32'h00000001, "idle request");
    $display("test receive and idle done");
  endtask
  task automatic t_err;
    rem.send(9'h03C, 8, 1'b0);
    cyc(4);
    st(8'hF4, 8'h44, "framing error");
    rem.send(9'h055, 8, 1'b1);
    cyc(4);
    st(8'hF4, 8'h14, "overrun wins");
    wb(1'b0, ADDR_RX_DATA, 8'h00);
    chk(rd, 32'h0000003C, "old byte kept");
    st(8'hF4, 8'h00, "status then data clears");
    wb(1'b0, ADDR_RX_DATA, 8'h00);
    rem.send(9'h011, 8, 1'b1);
    rem.send(9'h022, 8, 1'b1);
    cyc(4);
    wb(1'b0, ADDR_RX_DATA, 8'h00);
    chk(rd, 32'h00000011, "first byte kept");
    st(8'hF4, 8'h10, "data read alone keeps overrun");
    wb(1'b1, ADDR_TX_DATA1, 8'h77);
    stop_i <= 1'b1;
    cyc(12);
    st(8'hF6, 8'h02, "stop clears overrun");
    stop_i <= 1'b0;
    cyc(400);
    $display("test receive errors done");
  endtask
  task automatic t_par;
    wb(1'b1, ADDR_CTRL, 8'h01);
    rem.send(9'h10F, 9, 1'b1);
    cyc(4);
    st(8'h74, 8'h24, "parity error");
    wb(1'b0, ADDR_RX_DATA, 8'h00);
    rem.send(9'h003, 9, 1'b1);
    cyc(4);
    st(8'h74, 8'h04, "transfer after parity");
    wb(1'b0, ADDR_RX_DATA, 8'h00);
    chk(rd, 32'h00000003, "byte after parity");
    cyc(9 * 32);
    st(8'h08, 8'h00, "long format idle too early");
    cyc(2 * 32);
    st(8'h08, 8'h08, "idle after eleven ones");
    $display("test parity done");
  endtask
  task automatic t_tx;
    wb(1'b1, ADDR_CTRL, 8'h00);
    wb(1'b1, ADDR_TX_DATA0, 8'h5A);
    st(8'h03, 8'h00, "write clears flags");
    cyc(22);
    st(8'h02, 8'h00, "flag before data bit");
    cyc(10);
    st(8'h02, 8'h02, "flag in first data bit");
    cyc(300);
    st(8'h03, 8'h03, "both empty");
    chk({24'h000000, rem.got}, 32'h0000005A, "first word sent");
    wb(1'b1, ADDR_CTRL, 8'h20);
    st(8'h01, 8'h00, "break clears");
    cyc(400);
    $display("test transmit done");
  endtask
  task automatic t_sync;
    wb(1'b1, ADDR_CTRL, 8'h03);
    wb(1'b1, ADDR_TX_DATA2, 8'hC3);
    cyc(2);
    st(8'h02, 8'h00, "sync flag before load");
    cyc(13);
    st(8'h02, 8'h02, "sync flag in time");
    cyc(100);
    $display("test sync done");
  endtask
  task automatic t_ext;
    wb(1'b1, ADDR_CTRL, 8'h08);
    wb(1'b1, ADDR_TX_ADDR, 8'h96);
    rem.clock(8);
    cyc(30);
    st(8'h02, 8'h00, "halted with clock");
    rem.clock(24);
    cyc(4);
    st(8'h02, 8'h02, "resumed clock");
    rem.clock(150);
    cyc(8);
    wb(1'b1, ADDR_CTRL, 8'h00);
    $display("test external clock done");
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    rst_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 5'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h00000000;
    stop_i = 1'b0;
    cyc(6);
    rst_i <= 1'b0;
    cyc(1);
    t_reset();
    t_rx();
    t_err();
    t_par();
    t_tx();
    t_sync();
    t_ext();
    final_report();
  end
endmodule
